/* File: src/ccd_pkg.sv */
// Package holding shared constants and types of the clock distribution block
package ccd_pkg;
  // Network dimensions
  localparam int NUM_SRC = 7;
  localparam int NUM_DIG = 8;
  localparam int NUM_ANA = 4;
  localparam int NUM_MUX = 8;
  localparam int SEL_W = 3;
  localparam int RATIO_W = 16;
  localparam int CPU_W = 4;
  localparam int SKEW_W = 4;
  localparam int SKEW_DEPTH = 16;
  localparam int SYNC_W = NUM_SRC + NUM_DIG;

  // Source indices on the eight-way multiplexer
  localparam logic [2:0] SRC_FAST_OSC = 3'h0;
  localparam logic [2:0] SRC_XTAL_HF = 3'h1;
  localparam logic [2:0] SRC_FABRIC = 3'h2;
  localparam logic [2:0] SRC_PLL = 3'h3;
  localparam logic [2:0] SRC_DOUBLER = 3'h4;
  localparam logic [2:0] SRC_LOW_OSC = 3'h5;
  localparam logic [2:0] SRC_XTAL_LF = 3'h6;
  localparam logic [2:0] SRC_EXTRA = 3'h7;

  // Reset values and ratio limits
  localparam logic [RATIO_W-1:0] RATIO_MIN = 16'h0002;
  localparam logic [RATIO_W-1:0] RATIO_RST = 16'h0002;
  localparam logic [CPU_W-1:0] CPU_RATIO_RST = 4'h0;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  localparam logic [SKEW_W-1:0] SKEW_RST = 4'h0;

  // Timing figures
  localparam int SYS_CLK_MHZ = 50;
  localparam int USB_CLK_MHZ = 48;
  localparam int USB_HALF_MHZ = 24;

  // Origin of the 48 MHz processing clock
  typedef enum logic [0:0] {
    CCD_USB_FABRIC48,
    CCD_USB_DOUBLED24
  } ccd_usb_src_t;
endpackage

/* File: src/ccd_div_if.sv */
// Interface carrying configuration and output of one divider
`timescale 1ns/1ps
interface ccd_div_if;
  logic en;
  logic [ccd_pkg::SEL_W-1:0] sel;
  logic [ccd_pkg::RATIO_W-1:0] ratio;
  logic [ccd_pkg::SKEW_W-1:0] skew;
  logic out;
  modport ctrl (output en, output sel, output ratio, output skew, input out);
  modport div (input en, input sel, input ratio, input skew, output out);
endinterface

/* File: src/ccd_sync3.sv */
// Three-stage input synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module ccd_sync3 #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
  } ccd_sync_t;

  ccd_sync_t st_q;
  ccd_sync_t st_d;

  // Level changes only once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
    st_d.rise = st_d.lvl & ~st_q.lvl;
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;
  assign rise = st_q.rise;
endmodule

/* File: src/ccd_div.sv */
// One 16-bit clock divider with source mux, deglitching and optional skew
`timescale 1ns/1ps
module ccd_div #(
  parameter bit SKEW_EN = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ccd_pkg::NUM_MUX-1:0] src_rise,
  ccd_div_if.div cfg
);
  typedef struct packed {
    logic run;
    logic [ccd_pkg::SEL_W-1:0] sel;
    logic [ccd_pkg::RATIO_W-1:0] ratio;
    logic [ccd_pkg::RATIO_W-1:0] cnt;
    logic [ccd_pkg::SKEW_W-1:0] skew;
    logic raw;
    logic [ccd_pkg::SKEW_DEPTH-1:0] dly;
    logic out;
  } ccd_div_t;

  ccd_div_t st_q;
  ccd_div_t st_d;
  logic tick;
  logic [ccd_pkg::RATIO_W-1:0] half;

  always_comb begin
    st_d = st_q;
    tick = src_rise[st_q.sel]; // Eight-way source selection
    half = '0;
    if (!st_q.run) begin
      // Idle: latch a fresh setting only when enabled
      if (cfg.en) begin
        st_d.run = 1'b1;
        st_d.sel = cfg.sel;
        st_d.ratio = (cfg.ratio < ccd_pkg::RATIO_MIN) ? ccd_pkg::RATIO_MIN : cfg.ratio;
        st_d.skew = cfg.skew;
        // Start in the low phase so the first high half is whole
        st_d.cnt = st_d.ratio - 16'h0001;
      end
    end else if (tick) begin
      if (st_q.cnt == st_q.ratio - 16'h0001) begin
        // Changes take effect only at a period boundary
        st_d.cnt = '0;
        st_d.run = cfg.en;
        st_d.sel = cfg.sel;
        st_d.ratio = (cfg.ratio < ccd_pkg::RATIO_MIN) ? ccd_pkg::RATIO_MIN : cfg.ratio;
        st_d.skew = cfg.skew;
        // A new source starts low and waits for its own first edge
        if (cfg.sel != st_q.sel) begin
          st_d.cnt = st_d.ratio - 16'h0001;
        end
      end else begin
        st_d.cnt = st_q.cnt + 16'h0001;
      end
    end
    // High for the first half of the period
    half = st_d.ratio >> 1;
    st_d.raw = st_d.run && (st_d.cnt < half);
    st_d.dly = {st_q.dly[ccd_pkg::SKEW_DEPTH-2:0], st_q.raw};
    // Skew delays the output by whole system clock cycles
    if (SKEW_EN && (st_q.skew != ccd_pkg::SKEW_RST)) begin
      st_d.out = st_q.dly[st_q.skew - 4'h1];
    end else begin
      st_d.out = st_q.raw;
    end
  end

  // State register, output resynchronised to the system clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg.out = st_q.out;
endmodule

/* File: src/ccd_clock_dist.sv */
// Top of the clock distribution network with bus, CPU, digital, analog and USB clocks
`timescale 1ns/1ps
module ccd_clock_dist (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ccd_pkg::NUM_SRC-1:0] src_clk,
  input wire logic [ccd_pkg::NUM_SRC-1:0] src_avail,
  input wire logic [ccd_pkg::NUM_DIG-1:0] fabric_clk,
  input wire logic [ccd_pkg::NUM_DIG-1:0] dig_en,
  input wire logic [ccd_pkg::NUM_DIG-1:0][ccd_pkg::SEL_W-1:0] dig_sel,
  input wire logic [ccd_pkg::NUM_DIG-1:0][ccd_pkg::RATIO_W-1:0] dig_ratio,
  input wire logic [ccd_pkg::NUM_DIG-1:0] dig_chain,
  input wire logic [ccd_pkg::NUM_ANA-1:0] ana_en,
  input wire logic [ccd_pkg::NUM_ANA-1:0][ccd_pkg::SEL_W-1:0] ana_sel,
  input wire logic [ccd_pkg::NUM_ANA-1:0][ccd_pkg::RATIO_W-1:0] ana_ratio,
  input wire logic [ccd_pkg::NUM_ANA-1:0][ccd_pkg::SKEW_W-1:0] ana_skew,
  input wire logic [ccd_pkg::RATIO_W-1:0] bus_ratio,
  input wire logic [ccd_pkg::CPU_W-1:0] cpu_ratio,
  input wire logic usb_src_sel,
  output logic [ccd_pkg::SEL_W-1:0] sys_src_sel_q,
  output logic sys_src_ok_q,
  output logic bus_clk_q,
  output logic bus_tick_q,
  output logic cpu_clk_q,
  output logic cpu_tick_q,
  output logic [ccd_pkg::NUM_DIG-1:0] dig_clk_q,
  output logic [ccd_pkg::NUM_ANA-1:0] ana_clk_q,
  output logic usb_clk_sel_q,
  output logic usb_clk_q,
  output logic usb_bus_en_q
);
  typedef struct packed {
    logic [ccd_pkg::SEL_W-1:0] sys_sel;
    logic sys_ok;
    logic [ccd_pkg::RATIO_W-1:0] bus_cnt;
    logic [ccd_pkg::RATIO_W-1:0] bus_ratio;
    logic bus_clk;
    logic bus_tick;
    logic [ccd_pkg::CPU_W-1:0] cpu_cnt;
    logic [ccd_pkg::CPU_W-1:0] cpu_ratio;
    logic cpu_clk;
    logic cpu_tick;
    logic [ccd_pkg::NUM_DIG-1:0] dig;
    logic [ccd_pkg::NUM_DIG-1:0] dig_rise;
    logic [ccd_pkg::NUM_ANA-1:0] ana;
    logic usb_sel;
    logic usb_clk;
    logic usb_bus_en;
  } ccd_top_t;

  ccd_top_t st_q;
  ccd_top_t st_d;

  logic [ccd_pkg::SYNC_W-1:0] sync_lvl;
  logic [ccd_pkg::SYNC_W-1:0] sync_rise;
  logic [ccd_pkg::NUM_SRC-1:0] src_rise;
  logic [ccd_pkg::NUM_DIG-1:0] fab_rise;
  logic [ccd_pkg::NUM_DIG-1:0] dig_out;
  logic [ccd_pkg::NUM_ANA-1:0] ana_out;
  logic [ccd_pkg::SEL_W-1:0] fast_sel;
  logic fast_ok;
  logic [ccd_pkg::RATIO_W-1:0] bus_div;

  ////////////////////////////////////////////////////////////////////////////////
  // Source sampling

  // All sources and fabric clocks pass the three-stage synchroniser
  ccd_sync3 #(
    .W(ccd_pkg::SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({fabric_clk, src_clk}),
    .level(sync_lvl),
    .rise(sync_rise)
  );

  assign src_rise = sync_rise[ccd_pkg::NUM_SRC-1:0];
  assign fab_rise = sync_rise[ccd_pkg::SYNC_W-1:ccd_pkg::NUM_SRC];

  ////////////////////////////////////////////////////////////////////////////////
  // System clock selector

  // Fixed ranking from fastest to slowest among available sources
  always_comb begin
    fast_sel = ccd_pkg::SRC_FAST_OSC;
    fast_ok = 1'b1;
    if (src_avail[ccd_pkg::SRC_PLL]) begin
      fast_sel = ccd_pkg::SRC_PLL;
    end else if (src_avail[ccd_pkg::SRC_DOUBLER]) begin
      fast_sel = ccd_pkg::SRC_DOUBLER;
    end else if (src_avail[ccd_pkg::SRC_XTAL_HF]) begin
      fast_sel = ccd_pkg::SRC_XTAL_HF;
    end else if (src_avail[ccd_pkg::SRC_FAST_OSC]) begin
      fast_sel = ccd_pkg::SRC_FAST_OSC;
    end else if (src_avail[ccd_pkg::SRC_FABRIC]) begin
      fast_sel = ccd_pkg::SRC_FABRIC;
    end else if (src_avail[ccd_pkg::SRC_LOW_OSC]) begin
      fast_sel = ccd_pkg::SRC_LOW_OSC;
    end else if (src_avail[ccd_pkg::SRC_XTAL_LF]) begin
      fast_sel = ccd_pkg::SRC_XTAL_LF;
    end else begin
      fast_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Digital and analog dividers

  // Clamp bus ratio to the legal minimum
  assign bus_div = (bus_ratio < ccd_pkg::RATIO_MIN) ? ccd_pkg::RATIO_MIN : bus_ratio;

  ccd_div_if dig_if[ccd_pkg::NUM_DIG] ();
  ccd_div_if ana_if[ccd_pkg::NUM_ANA] ();

  genvar gi;
  generate
    for (gi = 0; gi < ccd_pkg::NUM_DIG; gi++) begin : g_dig
      logic extra_rise;
      // Input seven is the private fabric clock or the previous divider for cascading
      assign extra_rise = dig_chain[gi] ? st_q.dig_rise[(gi + ccd_pkg::NUM_DIG - 1) % ccd_pkg::NUM_DIG]
                                        : fab_rise[gi];
      assign dig_if[gi].en = dig_en[gi];
      assign dig_if[gi].sel = dig_sel[gi];
      assign dig_if[gi].ratio = dig_ratio[gi];
      assign dig_if[gi].skew = ccd_pkg::SKEW_RST;
      assign dig_out[gi] = dig_if[gi].out;
      // Any of the seven sources may drive each digital divider
      ccd_div #(
        .SKEW_EN(1'b0)
      ) u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_rise({extra_rise, src_rise}),
        .cfg(dig_if[gi])
      );
    end
    for (gi = 0; gi < ccd_pkg::NUM_ANA; gi++) begin : g_ana
      assign ana_if[gi].en = ana_en[gi];
      assign ana_if[gi].sel = ana_sel[gi];
      assign ana_if[gi].ratio = ana_ratio[gi];
      assign ana_if[gi].skew = ana_skew[gi];
      assign ana_out[gi] = ana_if[gi].out;
      // Input seven is the system clock itself; skew enabled
      ccd_div #(
        .SKEW_EN(1'b1)
      ) u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .src_rise({1'b1, src_rise}),
        .cfg(ana_if[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Bus, CPU and USB clocks

  always_comb begin
    st_d = st_q;
    st_d.sys_sel = fast_sel;
    st_d.sys_ok = fast_ok;
    // Bus divider counts system clock cycles, new ratio at period end
    st_d.bus_tick = 1'b0;
    if (st_q.bus_cnt >= st_q.bus_ratio - 16'h0001) begin
      st_d.bus_cnt = '0;
      st_d.bus_ratio = bus_div;
      st_d.bus_tick = 1'b1;
    end else begin
      st_d.bus_cnt = st_q.bus_cnt + 16'h0001;
    end
    st_d.bus_clk = st_d.bus_cnt < (st_d.bus_ratio >> 1);
    // CPU divider counts bus ticks, divide by ratio plus one
    st_d.cpu_tick = 1'b0;
    if (st_q.bus_tick) begin
      if (st_q.cpu_cnt >= st_q.cpu_ratio) begin
        st_d.cpu_cnt = '0;
        st_d.cpu_ratio = cpu_ratio;
        st_d.cpu_tick = 1'b1;
      end else begin
        st_d.cpu_cnt = st_q.cpu_cnt + 4'h1;
      end
    end
    st_d.cpu_clk = (st_d.cpu_ratio == ccd_pkg::CPU_RATIO_RST) ? st_d.bus_clk
                   : (st_d.cpu_cnt <= (st_d.cpu_ratio >> 1));
    // Cascade edges and registered divider outputs
    st_d.dig = dig_out;
    st_d.dig_rise = dig_out & ~st_q.dig;
    st_d.ana = ana_out;
    // USB clock origin changes only while the selected clock is low
    if (!st_q.usb_clk) begin
      st_d.usb_sel = usb_src_sel;
    end
    st_d.usb_clk = (st_q.usb_sel == ccd_pkg::CCD_USB_DOUBLED24) ? sync_lvl[ccd_pkg::SRC_DOUBLER]
                   : sync_lvl[ccd_pkg::SRC_FABRIC];
    // USB bus side is enabled on bus clock ticks only
    st_d.usb_bus_en = st_d.bus_tick;
  end

  // State register with defined reset values
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.bus_ratio <= ccd_pkg::RATIO_RST;
      st_q.cpu_ratio <= ccd_pkg::CPU_RATIO_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign sys_src_sel_q = st_q.sys_sel;
  assign sys_src_ok_q = st_q.sys_ok;
  assign bus_clk_q = st_q.bus_clk;
  assign bus_tick_q = st_q.bus_tick;
  assign cpu_clk_q = st_q.cpu_clk;
  assign cpu_tick_q = st_q.cpu_tick;
  assign dig_clk_q = st_q.dig;
  assign ana_clk_q = st_q.ana;
  assign usb_clk_sel_q = st_q.usb_sel;
  assign usb_clk_q = st_q.usb_clk;
  assign usb_bus_en_q = st_q.usb_bus_en;
endmodule

/* File: test/ccd_clock_dist_asserts.sv */
// Checker for the clock distribution top ports
`timescale 1ns/1ps
module ccd_clock_dist_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [6:0] src_avail,
  input wire logic [7:0] dig_en,
  input wire logic [3:0] ana_en,
  input wire logic [15:0] bus_ratio,
  input wire logic [2:0] sys_src_sel_q,
  input wire logic sys_src_ok_q,
  input wire logic bus_clk_q,
  input wire logic bus_tick_q,
  input wire logic cpu_tick_q,
  input wire logic [7:0] dig_clk_q,
  input wire logic [3:0] ana_clk_q,
  input wire logic usb_clk_sel_q,
  input wire logic usb_clk_q,
  input wire logic usb_bus_en_q
);
  localparam logic [2:0] RANK [7] = '{3'h6, 3'h5, 3'h2, 3'h0, 3'h1, 3'h4, 3'h3};
  logic [2:0] best_c;
  logic [7:0] dig_seen_q;
  logic [3:0] ana_seen_q;
  logic [15:0] ratio_q;
  logic [3:0] stab_q;
  // Fastest available source, slow ones ranked first so faster ones win
  always_comb begin
    best_c = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (src_avail[RANK[i]]) begin
        best_c = RANK[i];
      end
    end
  end
  // Enables seen since reset and cycles since the bus ratio last moved
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dig_seen_q <= 8'h00;
      ana_seen_q <= 4'h0;
      ratio_q <= 16'h0000;
      stab_q <= 4'h0;
    end else begin
      dig_seen_q <= dig_seen_q | dig_en;
      ana_seen_q <= ana_seen_q | ana_en;
      ratio_q <= bus_ratio;
      stab_q <= (bus_ratio != ratio_q) ? 4'h0 : ((stab_q == 4'hf) ? stab_q : stab_q + 4'h1);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_sys_sel_best: assert property ($past(rst_n) && $past(|src_avail) |-> sys_src_sel_q == $past(best_c))
    else $error("system source is not the fastest available");
  a_sys_ok_any: assert property ($past(rst_n) |-> sys_src_ok_q == $past(|src_avail))
    else $error("source ok flag wrong");
  a_bus_period: assert property (bus_tick_q && bus_ratio == 16'h0004 && stab_q > 4'h8
    |=> !bus_tick_q [*3] ##1 bus_tick_q) else $error("bus period wrong");
  a_bus_duty: assert property ($rose(bus_clk_q) && bus_ratio == 16'h0004 && stab_q > 4'h8
    |=> bus_clk_q ##1 !bus_clk_q [*2] ##1 bus_clk_q) else $error("bus duty wrong");
  a_cpu_tick_one: assert property (cpu_tick_q |=> !cpu_tick_q)
    else $error("cpu tick longer than one cycle");
  a_usb_sel_low: assert property ($changed(usb_clk_sel_q) |-> !$past(usb_clk_q))
    else $error("usb source switched while clock high");
  a_dig_off_low: assert property ((dig_clk_q & ~dig_seen_q) == 8'h00)
    else $error("digital clock active before enable");
  a_ana_off_low: assert property ((ana_clk_q & ~ana_seen_q) == 4'h0)
    else $error("analog clock active before enable");
  a_dig_no_runt: assert property ($rose(dig_clk_q[0]) |=> dig_clk_q[0])
    else $error("runt pulse on digital clock");
  a_usb_bus_tick: assert property (usb_bus_en_q == bus_tick_q)
    else $error("usb bus enable off the bus tick");
endmodule
bind ccd_clock_dist ccd_clock_dist_asserts u_ccd_clock_dist_asserts (.sys_clk, .rst_n, .src_avail, .dig_en,
  .ana_en, .bus_ratio, .sys_src_sel_q, .sys_src_ok_q, .bus_clk_q, .bus_tick_q, .cpu_tick_q, .dig_clk_q,
  .ana_clk_q, .usb_clk_sel_q, .usb_clk_q, .usb_bus_en_q);

/* File: test/ccd_src_model.sv */
// Free running clock sources and fabric clocks feeding the network
`timescale 1ns/1ps
module ccd_src_model (
  output logic [6:0] src_clk,
  output logic [7:0] fabric_clk
);
  // Source k toggles every k+3 system cycles, offset off the sampling edge
  for (genvar k = 0; k < 8; k++) begin : g_osc
    initial begin
      fabric_clk[k] = 1'b0;
      #5;
      forever begin
        #((k + 3) * 20);
        fabric_clk[k] = ~fabric_clk[k];
      end
    end
  end
  assign src_clk = fabric_clk[6:0];
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the clock distribution network
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rst_n, usb_src_sel;
  logic [6:0] src_clk, src_avail;
  logic [7:0] fabric_clk, dig_en, dig_chain, dig_clk_q;
  logic [7:0][2:0] dig_sel;
  logic [7:0][15:0] dig_ratio;
  logic [3:0] ana_en, cpu_ratio, ana_clk_q;
  logic [3:0][2:0] ana_sel;
  logic [3:0][15:0] ana_ratio;
  logic [3:0][3:0] ana_skew;
  logic [15:0] bus_ratio;
  logic [2:0] sys_src_sel_q;
  logic sys_src_ok_q, bus_clk_q, bus_tick_q, cpu_clk_q, cpu_tick_q, usb_clk_sel_q, usb_clk_q, usb_bus_en_q;
  int fail_count, checks, n, m;
  ccd_src_model u_ccd_src_model (.src_clk, .fabric_clk);
  ccd_clock_dist u_ccd_clock_dist (.sys_clk, .rst_n, .src_clk, .src_avail, .fabric_clk, .dig_en, .dig_sel,
    .dig_ratio, .dig_chain, .ana_en, .ana_sel, .ana_ratio, .ana_skew, .bus_ratio, .cpu_ratio, .usb_src_sel,
    .sys_src_sel_q, .sys_src_ok_q, .bus_clk_q, .bus_tick_q, .cpu_clk_q, .cpu_tick_q, .dig_clk_q, .ana_clk_q,
    .usb_clk_sel_q, .usb_clk_q, .usb_bus_en_q);
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog
  initial begin
    #200_000;
    fail_count++;
    wrap_up();
  end
  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %0d expected %0d", $time, seen, exp);
    end
  endtask
  function automatic logic sig(input int i);
    if (i < 8) return dig_clk_q[i];
    if (i < 12) return ana_clk_q[i-8];
    if (i == 12) return bus_clk_q;
    if (i == 13) return cpu_clk_q;
    if (i == 14) return usb_clk_q;
    if (i == 15) return cpu_tick_q;
    if (i == 16) return bus_tick_q;
    return usb_bus_en_q;
  endfunction
  // Counts settled cycles until the watched clock reaches a level
  task automatic wait_lvl(input int i, input logic v, output int c);
    c = 0;
    while (sig(i) !== v && c < 3000) begin
      @(negedge sys_clk);
      c++;
    end
    if (c >= 3000) begin
      fail_count++;
      $display("BAD %0t level wait timed out", $time);
    end
  endtask
  // Third full period after a change: compare period and high time
  task automatic mchk(input int i, input int p, input int h);
    int hi, lo;
    repeat (2) begin
      wait_lvl(i, 1'b0, hi);
      wait_lvl(i, 1'b1, hi);
      wait_lvl(i, 1'b0, hi);
      wait_lvl(i, 1'b1, lo);
    end
    chk(hi + lo, p);
    chk(hi, h);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sys_sel();
    logic [6:0] av [7] = '{7'h7f, 7'h77, 7'h67, 7'h65, 7'h64, 7'h60, 7'h40};
    logic [2:0] ex [7] = '{3'h3, 3'h4, 3'h1, 3'h0, 3'h2, 3'h5, 3'h6};
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      src_avail <= av[i];
      repeat (2) @(negedge sys_clk);
      chk(sys_src_sel_q, ex[i]);
    end
    @(posedge sys_clk);
    src_avail <= 7'h00;
    repeat (2) @(negedge sys_clk);
    chk(sys_src_ok_q, 1'b0);
    @(posedge sys_clk);
    src_avail <= 7'h7f;
  endtask
  task automatic t_bus_cpu();
    mchk(12, 4, 2);
    mchk(16, 4, 1);
    mchk(17, 4, 1);
    @(posedge sys_clk);
    bus_ratio <= 16'h0006;
    mchk(12, 6, 3);
    @(posedge sys_clk);
    bus_ratio <= 16'h0004;
    cpu_ratio <= 4'h2;
    mchk(15, 12, 1);
    @(posedge sys_clk);
    cpu_ratio <= 4'h0;
    mchk(13, 4, 2);
  endtask
  task automatic t_dig();
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      dig_sel[i] <= i[2:0];
      dig_ratio[i] <= (i == 2) ? 16'h0000 : 16'h0002;
    end
    dig_en <= 8'hff;
    for (int i = 0; i < 8; i++) begin
      mchk(i, 4 * (i + 3), 2 * (i + 3));
    end
    @(posedge sys_clk);
    dig_chain <= 8'h02;
    dig_sel[1] <= 3'h7;
    dig_ratio[1] <= 16'h0003;
    mchk(1, 36, 12);
  endtask
  task automatic t_ana();
    @(posedge sys_clk);
    ana_sel <= {4{3'h7}};
    ana_ratio <= {4{16'h0004}};
    ana_skew <= 16'h0030;
    ana_en <= 4'hf;
    mchk(8, 4, 2);
    wait_lvl(8, 1'b0, n);
    wait_lvl(8, 1'b1, n);
    wait_lvl(9, 1'b0, n);
    wait_lvl(9, 1'b1, m);
    chk(n + m, 3);
  endtask
  task automatic t_usb_off();
    @(posedge sys_clk);
    usb_src_sel <= 1'b1;
    mchk(14, 14, 7);
    chk(usb_clk_sel_q, 1'b1);
    @(posedge sys_clk);
    usb_src_sel <= 1'b0;
    mchk(14, 10, 5);
    @(posedge sys_clk);
    dig_en <= 8'h00;
    dig_chain <= 8'h00; // Unchained so divider one still sees edges to end its period
    ana_en <= 4'h0;
    repeat (150) @(negedge sys_clk);
    chk(dig_clk_q, 8'h00);
    chk(ana_clk_q, 4'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    usb_src_sel = 1'b0;
    src_avail = 7'h7f;
    {dig_en, dig_chain, ana_en, cpu_ratio} = 24'h00_0000;
    {dig_sel, ana_sel, ana_skew} = 52'h0;
    dig_ratio = {8{16'h0002}};
    ana_ratio = {4{16'h0002}};
    bus_ratio = 16'h0004;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (20) @(negedge sys_clk);
    chk(dig_clk_q, 8'h00);
    chk(ana_clk_q, 4'h0);
    t_sys_sel();
    t_bus_cpu();
    t_dig();
    t_ana();
    t_usb_off();
    wrap_up();
  end
endmodule
